// ---- hw/tlr_consts.svh ----
// Offsets, field positions and reset values of the top-level register group
`ifndef TLR_CONSTS_SVH
`define TLR_CONSTS_SVH

`define TLR_ADDR_CHIP_ID      8'h00
`define TLR_ADDR_SOFT_RESET   8'h01
`define TLR_ADDR_EVENT_FLAGS  8'h02
`define TLR_ADDR_EVENT_MASKS  8'h03
`define TLR_ADDR_LIVE_STATUS  8'h04

`define TLR_SOFT_RESET_KEY    8'ha5
`define TLR_KEY_RESET_VALUE   8'h00
`define TLR_FLAGS_RESET_VALUE 3'h0
`define TLR_MASKS_RESET_VALUE 8'hff
`define TLR_STATUS_RESET_VALUE 3'h7
`define TLR_RAW_RESET_VALUE   3'h0

`define TLR_BIT_THERMAL       2
`define TLR_BIT_SYS_OV        1
`define TLR_BIT_SYS_UV        0
`define TLR_EVENT_COUNT       3
`define TLR_SPARE_ZERO        5'h00
`define TLR_UNMAPPED_READ     8'h00

`endif

// ---- hw/tlr_pkg.sv ----
// Types shared by the top-level register group
`default_nettype none
package tlr_pkg;
    typedef logic [7:0] tlr_byte_t;
    typedef logic [2:0] tlr_events_t;
endpackage
`default_nettype wire

// ---- hw/tlr_top_regs.sv ----
// Top-level identification, soft reset key and event flag registers
//
// Summary of operation
// - Writing key 0xA5 resets key and masks to their reset values and clears the flags, except a flag whose status changes in that same cycle.
// - The key register is soft-resettable, so it clears itself after the key.
// - Any other value written to the key register is stored and reads back.
// - Each event flag reads 0 until an event is seen, then 1 until the flags register is read or the key is written.
// - Thermal status reads 0 in thermal shutdown, 1 otherwise.
// - Overvoltage status reads 0 above the threshold, 1 below it.
// - Undervoltage status reads 0 below the threshold, 1 above it.
`timescale 1ns/1ps
`default_nettype none
`include "tlr_consts.svh"

module tlr_top_regs #(
    parameter logic [2:0] REVISION = 3'h2,  // Arbitrary value
    parameter logic [4:0] VERSION  = 5'h01  // Arbitrary value
) (
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire logic [7:0]      regAddr,
    input  wire logic [7:0]      regWrData,
    input  wire logic            regWr,
    input  wire logic            regRd,
    output var  tlr_pkg::tlr_byte_t regRdData,
    output var  logic            softResetPulse,
    input  wire logic            thermalShutdown,
    input  wire logic            sysAboveOv,
    input  wire logic            sysBelowUv
);

    // Condition inputs come from analog comparators, so they are synchronised
    tlr_pkg::tlr_events_t rawCond;
    tlr_pkg::tlr_events_t syncFirst;
    tlr_pkg::tlr_events_t syncSecond;
    tlr_pkg::tlr_events_t status;
    tlr_pkg::tlr_events_t okNow;

    tlr_pkg::tlr_byte_t   softResetKey;
    tlr_pkg::tlr_byte_t   eventMasks;
    tlr_pkg::tlr_events_t eventFlags;

    tlr_pkg::tlr_byte_t   next_regRdData;
    logic                 next_softResetPulse;
    tlr_pkg::tlr_byte_t   next_softResetKey;
    tlr_pkg::tlr_byte_t   next_eventMasks;
    tlr_pkg::tlr_events_t next_eventFlags;

    logic                 keyHit;
    logic                 flagsRead;
    tlr_pkg::tlr_events_t changed;

    // Pins enter the synchroniser untouched; no logic reads them before two flops
    assign rawCond[`TLR_BIT_THERMAL] = thermalShutdown;
    assign rawCond[`TLR_BIT_SYS_OV]  = sysAboveOv;
    assign rawCond[`TLR_BIT_SYS_UV]  = sysBelowUv;

    assign okNow = ~syncSecond;

    always_comb
    begin
        keyHit    = regWr && (regAddr == `TLR_ADDR_SOFT_RESET)
                    && (regWrData == `TLR_SOFT_RESET_KEY);
        flagsRead = regRd && (regAddr == `TLR_ADDR_EVENT_FLAGS);
        changed   = okNow ^ status;

        next_softResetPulse = keyHit;
        next_softResetKey   = softResetKey;
        next_eventMasks     = eventMasks;
        next_eventFlags     = eventFlags;

        if (regWr && regAddr == `TLR_ADDR_SOFT_RESET)
        begin
            next_softResetKey = regWrData;
        end
        if (regWr && regAddr == `TLR_ADDR_EVENT_MASKS)
        begin
            next_eventMasks = regWrData;
        end
        if (flagsRead)
        begin
            next_eventFlags = `TLR_FLAGS_RESET_VALUE;
        end
        if (keyHit)
        begin
            next_softResetKey = `TLR_KEY_RESET_VALUE;
            next_eventMasks   = `TLR_MASKS_RESET_VALUE;
            next_eventFlags   = `TLR_FLAGS_RESET_VALUE;
        end
        next_eventFlags = next_eventFlags | changed;

        next_regRdData = regRdData;
        if (regRd)
        begin
            case (regAddr)
                `TLR_ADDR_CHIP_ID:     next_regRdData = {REVISION, VERSION};
                `TLR_ADDR_SOFT_RESET:  next_regRdData = softResetKey;
                `TLR_ADDR_EVENT_FLAGS: next_regRdData = {`TLR_SPARE_ZERO, eventFlags};
                `TLR_ADDR_EVENT_MASKS: next_regRdData = eventMasks;
                `TLR_ADDR_LIVE_STATUS: next_regRdData = {`TLR_SPARE_ZERO, status};
                default:               next_regRdData = `TLR_UNMAPPED_READ;
            endcase
        end
    end

    // Three-flop path: two synchroniser stages, then the registered status
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            syncFirst  <= `TLR_RAW_RESET_VALUE;
            syncSecond <= `TLR_RAW_RESET_VALUE;
            status     <= `TLR_STATUS_RESET_VALUE;
        end
        else
        begin
            syncFirst  <= rawCond;
            syncSecond <= syncFirst;
            status     <= okNow;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regRdData      <= `TLR_UNMAPPED_READ;
            softResetPulse <= 1'b0;
            softResetKey   <= `TLR_KEY_RESET_VALUE;
            eventMasks     <= `TLR_MASKS_RESET_VALUE;
            eventFlags     <= `TLR_FLAGS_RESET_VALUE;
        end
        else
        begin
            regRdData      <= next_regRdData;
            softResetPulse <= next_softResetPulse;
            softResetKey   <= next_softResetKey;
            eventMasks     <= next_eventMasks;
            eventFlags     <= next_eventFlags;
        end
    end

    a_key_resets: assert property (@(posedge clk) disable iff (!reset_n)
        keyHit |=> softResetPulse && eventMasks == `TLR_MASKS_RESET_VALUE)
        else $error("key write did not reset masks");

    a_key_autoclear: assert property (@(posedge clk) disable iff (!reset_n)
        keyHit |=> softResetKey == `TLR_KEY_RESET_VALUE)
        else $error("key register did not clear");

    a_key_stores: assert property (@(posedge clk) disable iff (!reset_n)
        regWr && regAddr == `TLR_ADDR_SOFT_RESET && !keyHit
        |=> !softResetPulse && softResetKey == $past(regWrData))
        else $error("non-key value not stored or caused reset");

    a_flag_sets: assert property (@(posedge clk) disable iff (!reset_n)
        changed != '0 |=> (eventFlags & $past(changed)) == $past(changed))
        else $error("status change did not set flag");

    a_flag_holds: assert property (@(posedge clk) disable iff (!reset_n)
        !flagsRead && !keyHit |=> (eventFlags & $past(eventFlags)) == $past(eventFlags))
        else $error("flag lost without read");

    a_read_clears: assert property (@(posedge clk) disable iff (!reset_n)
        flagsRead && changed == '0
        |=> eventFlags == `TLR_FLAGS_RESET_VALUE && regRdData[2:0] == $past(eventFlags))
        else $error("flag read did not return and clear");

    a_thermal_status: assert property (@(posedge clk) disable iff (!reset_n)
        thermalShutdown [*4] |-> !status[`TLR_BIT_THERMAL])
        else $error("thermal status wrong in shutdown");

    a_ov_status: assert property (@(posedge clk) disable iff (!reset_n)
        sysAboveOv [*4] |-> !status[`TLR_BIT_SYS_OV])
        else $error("overvoltage status wrong");

    a_uv_status: assert property (@(posedge clk) disable iff (!reset_n)
        !sysBelowUv [*4] |-> status[`TLR_BIT_SYS_UV])
        else $error("undervoltage status wrong");

    a_thermal_ok: assert property (@(posedge clk) disable iff (!reset_n)
        !thermalShutdown [*4] |-> status[`TLR_BIT_THERMAL])
        else $error("thermal status wrong out of shutdown");

    a_ov_clear: assert property (@(posedge clk) disable iff (!reset_n)
        !sysAboveOv [*4] |-> status[`TLR_BIT_SYS_OV])
        else $error("overvoltage status wrong below threshold");

    a_uv_low: assert property (@(posedge clk) disable iff (!reset_n)
        sysBelowUv [*4] |-> !status[`TLR_BIT_SYS_UV])
        else $error("undervoltage status wrong below threshold");

    a_no_key_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        !keyHit |=> !softResetPulse)
        else $error("reset pulse without key");

    a_key_readback: assert property (@(posedge clk) disable iff (!reset_n)
        regRd && regAddr == `TLR_ADDR_SOFT_RESET |=> regRdData == $past(softResetKey))
        else $error("key register read back wrong");

    a_status_read: assert property (@(posedge clk) disable iff (!reset_n)
        regRd && regAddr == `TLR_ADDR_LIVE_STATUS
        |=> regRdData == {`TLR_SPARE_ZERO, $past(status)})
        else $error("status read back wrong");

    a_rddata_holds: assert property (@(posedge clk) disable iff (!reset_n)
        !regRd |=> $stable(regRdData))
        else $error("read data changed without read");

    a_key_clears_flags: assert property (@(posedge clk) disable iff (!reset_n)
        keyHit |=> eventFlags == (`TLR_FLAGS_RESET_VALUE | $past(changed)))
        else $error("key write did not clear flags");

endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the top-level register group
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic               clk = 0;
    logic               reset_n = 0;
    logic               regWr = 0;
    logic               regRd = 0;
    logic [2:0]         cond = 3'h0;
    logic [7:0]         regAddr = 8'h00;
    logic [7:0]         regWrData = 8'h00;
    tlr_pkg::tlr_byte_t regRdData;
    logic               softResetPulse;
    int                 fails = 0;
    int                 checksDone = 0;
    int                 model[5];
    logic [31:0]        v;

    tlr_top_regs dut_u (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .softResetPulse(softResetPulse), .thermalShutdown(cond[2]),
        .sysAboveOv(cond[1]), .sysBelowUv(cond[0]));

    initial
    begin
        forever #25 clk = ~clk;
    end

    task automatic finish_test();
        if (fails == 0 && checksDone > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWr = 1;
        @(posedge clk);
        #1;
        regWr = 0;
        if (a == 8'h03)
            model[3] = d;
        if (a == 8'h01)
            model[1] = d;
        if (a == 8'h01 && d == 8'ha5)
        begin
            model[1] = 0;
            model[2] = 0;
            model[3] = 8'hff;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        @(posedge clk);
        #1;
        regAddr = a;
        regRd = 1;
        @(posedge clk);
        #1;
        regRd = 0;
        e = (a < 8'h05) ? 8'(model[a]) : 8'h00;
        check(regRdData, e);
        if (a == 8'h02)
            model[2] = 0;
    endtask

    // Conditions pass three flops, so five edges let status settle
    task automatic flip(input logic [2:0] e);
        cond = cond ^ e;
        repeat (5) @(posedge clk);
        model[2] = model[2] | e;
        model[4] = 7 ^ cond;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial
    begin
        model = '{8'h41, 0, 0, 8'hff, 7};
        v = $urandom(75979);
        repeat (6) @(posedge clk);
        #1;
        reset_n = 1;
        for (int a = 0; a < 6; a++) rd(8'(a));
        repeat (2)
        begin
            for (int a = 0; a < 6; a++)
            begin
                v = $urandom;
                if (v[7:0] == 8'ha5)
                    v = 0;
                wr(8'(a), v[7:0]);
                rd(8'(a));
            end
        end
        repeat (6)
        begin
            v = $urandom;
            flip(v[2:0]);
            rd(8'h04);
            rd(8'h02);
            rd(8'h02);
        end
        flip(3'h5);
        wr(8'h01, 8'ha5);
        check({7'h00, softResetPulse}, 8'h01);
        @(posedge clk);
        #1;
        check({7'h00, softResetPulse}, 8'h00);
        for (int a = 1; a < 5; a++) rd(8'(a));
        // Mid-run reset while the pins show faults; flags then report the change
        reset_n = 0;
        cond = 3'h6;
        repeat (6) @(posedge clk);
        #1;
        check(regRdData, 8'h00);
        check({7'h00, softResetPulse}, 8'h00);
        reset_n = 1;
        model = '{8'h41, 0, cond, 8'hff, 7 ^ cond};
        for (int a = 0; a < 6; a++) rd(8'(a));
        rd(8'h02);
        finish_test();
    end
endmodule
`default_nettype wire
